// file: bench/iop_pins_model.sv
// Board model of the port pins: resolves the block's drive against external drivers.
`default_nettype none
module iop_pins_model (
  // Clock
  input wire logic clk,
  // Second port
  input wire logic [7:0] port2PinOut,
  input wire logic [7:0] port2PinOeN,
  input wire logic [7:0] port2Ext,
  input wire logic [7:0] port2ExtEn,
  output logic [7:0] port2Level,
  // Third port
  input wire logic [5:0] port3PinOut,
  input wire logic [5:0] port3PinOeN,
  input wire logic [5:0] port3Ext,
  input wire logic [5:0] port3ExtEn,
  output logic [5:0] port3Level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven pins have no pull, so they wander instead of settling to a convenient level.
  logic [7:0] noise_r = 8'h5a;
  always_ff @(posedge clk) noise_r <= ~noise_r;
  assign port2Level = (~port2PinOeN & port2PinOut) | (port2PinOeN & port2ExtEn & port2Ext)
    | (port2PinOeN & ~port2ExtEn & noise_r);
  assign port3Level = (~port3PinOeN & port3PinOut) | (port3PinOeN & port3ExtEn & port3Ext)
    | (port3PinOeN & ~port3ExtEn & noise_r[5:0]);
endmodule : iop_pins_model
`default_nettype wire

// file: bench/iop_ports_monitor.sv
// Concurrent checks on the I/O port block's pins and register reads.
`default_nettype none
`include "iop_cfg.svh"
module iop_ports_monitor
  import iop_pkg::*;
#(
  parameter int P3W = 6
) (
  // Clock and chip state
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] opMode,
  input wire logic hwStandby,
  input wire logic swStandby,
  // Register bus
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  // Bus byte and timer
  input wire logic [7:0] dataBusLowByteOut,
  input wire logic dataBusLowByteDrive,
  input wire logic [P3W-1:0] timerCompareEn,
  input wire logic [P3W-1:0] timerCompareLevel,
  // Pins
  input wire logic [7:0] port2PinOut,
  input wire logic [7:0] port2PinOeN,
  input wire logic [P3W-1:0] port3PinOut,
  input wire logic [P3W-1:0] port3PinOeN
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_P2DIR = 32'(`IOP_IDX_PORT2_DIR) << 2;
  localparam logic [31:0] A_P2DAT = 32'(`IOP_IDX_PORT2_DATA) << 2;
  localparam logic [31:0] A_P3DIR = 32'(`IOP_IDX_PORT3_DIR) << 2;
  localparam logic [31:0] A_P3DAT = 32'(`IOP_IDX_PORT3_DATA) << 2;
  // Pin checks wait until reset has been gone long enough for registered pins to settle.
  logic [1:0] up_r;
  wire logic live = (up_r == 2'h3);
  wire logic busMode = (opMode != 3'h0) && (opMode != 3'h2) && (opMode != 3'h7);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) up_r <= 2'h0;
    else if (!live) up_r <= up_r + 2'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_bus_drive: assert property (live && busMode && !swStandby && !hwStandby |=>
    port2PinOut == $past(dataBusLowByteOut) && port2PinOeN == {8{!$past(dataBusLowByteDrive)}})
    else $error("bus byte not on second port");
  a_sw_float: assert property (live && opMode != 3'h7 && swStandby |=> port2PinOeN == 8'hff)
    else $error("second port not floated in standby");
  a_timer_claim: assert property (live && |timerCompareEn && !swStandby && !hwStandby |=>
    (port3PinOeN & $past(timerCompareEn)) == '0 &&
    ((port3PinOut ^ $past(timerCompareLevel)) & $past(timerCompareEn)) == '0)
    else $error("timer level not on claimed pin");
  a_sw_timer: assert property (live && swStandby && $stable(swStandby) && !hwStandby &&
    $stable(hwStandby) && $stable(opMode) && !(bvalid && bready) |=>
    $stable(port3PinOut) && $stable(port3PinOeN))
    else $error("third port moved in standby");
  a_p3dir_read: assert property (arvalid && arready && araddr == A_P3DIR |->
    ##2 rvalid && rdata == 32'hff) else $error("third direction read wrong");
  a_p2dir_read: assert property (arvalid && arready && araddr == A_P2DIR |->
    ##2 rvalid && rdata == 32'hff) else $error("second direction read wrong");
  a_p2_busread: assert property (arvalid && arready && araddr == A_P2DAT && busMode |->
    ##2 rvalid && rdata == 32'hff) else $error("bus mode data read wrong");
  a_p3_upper: assert property (arvalid && arready && araddr == A_P3DAT |->
    ##2 rvalid && rdata[31:6] == 26'h3) else $error("third data upper bits wrong");
  c_write: cover property (bvalid && bready);
  c_sw_timer: cover property (swStandby && |timerCompareEn);
  c_bus: cover property (busMode && dataBusLowByteDrive && !swStandby);
endmodule : iop_ports_monitor
bind iop_ports iop_ports_monitor #(.P3W(P3W)) iop_ports_monitor_i (
  .clk(clk), .nrst(nrst), .opMode(opMode), .hwStandby(hwStandby), .swStandby(swStandby),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .dataBusLowByteOut(dataBusLowByteOut),
  .dataBusLowByteDrive(dataBusLowByteDrive), .timerCompareEn(timerCompareEn),
  .timerCompareLevel(timerCompareLevel), .port2PinOut(port2PinOut),
  .port2PinOeN(port2PinOeN), .port3PinOut(port3PinOut), .port3PinOeN(port3PinOeN));
`default_nettype wire

// file: bench/test_io_ports_two_and_three.sv
// Self-checking bench for the second and third I/O ports.
`default_nettype none
`include "iop_cfg.svh"
module test_io_ports_two_and_three;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_P2DIR = 32'(`IOP_IDX_PORT2_DIR) << 2;
  localparam logic [31:0] A_P2DAT = 32'(`IOP_IDX_PORT2_DATA) << 2;
  localparam logic [31:0] A_P3DIR = 32'(`IOP_IDX_PORT3_DIR) << 2;
  localparam logic [31:0] A_P3DAT = 32'(`IOP_IDX_PORT3_DATA) << 2;
  logic clk, nrst, hwStandby, swStandby, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, dataBusLowByteDrive;
  logic [2:0] opMode;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [7:0] dataBusLowByteOut, port2PinIn, port2PinOut, port2PinOeN, port2Ext, port2ExtEn;
  logic [5:0] timerCompareEn, timerCompareLevel, port3PinIn, port3PinOut, port3PinOeN;
  logic [5:0] port3Ext, port3ExtEn;
  logic [7:0] busByteIn;
  logic [1:0] lastResp;
  logic [2:0] busModes [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
  int failures = 0;
  int n_compared = 0;
  iop_ports #(.P3W(6)) iop_ports_i (.clk(clk), .nrst(nrst), .opMode(opMode),
    .hwStandby(hwStandby), .swStandby(swStandby), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dataBusLowByteOut(dataBusLowByteOut), .dataBusLowByteDrive(dataBusLowByteDrive),
    .dataBusLowByteIn(busByteIn), .timerCompareEn(timerCompareEn),
    .timerCompareLevel(timerCompareLevel), .port2PinIn(port2PinIn),
    .port2PinOut(port2PinOut), .port2PinOeN(port2PinOeN), .port3PinIn(port3PinIn),
    .port3PinOut(port3PinOut), .port3PinOeN(port3PinOeN));
  iop_pins_model iop_pins_model_i (.clk(clk), .port2PinOut(port2PinOut),
    .port2PinOeN(port2PinOeN), .port2Ext(port2Ext), .port2ExtEn(port2ExtEn),
    .port2Level(port2PinIn), .port3PinOut(port3PinOut), .port3PinOeN(port3PinOeN),
    .port3Ext(port3Ext), .port3ExtEn(port3ExtEn), .port3Level(port3PinIn));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic conclude();
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    lastResp = bresp;
    if (bvalid !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask : wr
  task automatic rdChk(input logic [31:0] a, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      failures++;
      conclude();
    end
    else chk(rdata, {24'h0, e});
  endtask : rdChk
  initial begin
    nrst <= 1'b0;
    opMode <= 3'h7;
    hwStandby <= 1'b0;
    swStandby <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, wdata, araddr} <= '0;
    wstrb <= 4'hf;
    dataBusLowByteOut <= 8'h00;
    dataBusLowByteDrive <= 1'b0;
    timerCompareEn <= 6'h00;
    timerCompareLevel <= 6'h00;
    port2Ext <= 8'h90;
    port2ExtEn <= 8'hf0;
    port3Ext <= 6'h15;
    port3ExtEn <= 6'h3f;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdChk(A_P3DIR, 8'hff);
    rdChk(A_P3DAT, 8'hd5);
    chk(port3PinOeN, 6'h3f);
    wr(A_P2DIR, 8'h0f);
    wr(A_P2DAT, 8'ha5);
    tick(2);
    chk(port2PinOeN, 8'hf0);
    chk(port2PinOut[3:0], 4'h5);
    rdChk(A_P2DAT, 8'h95);
    rdChk(A_P2DIR, 8'hff);
    wr(A_P3DIR, 8'h07);
    wr(A_P3DAT, 8'h2a);
    port3ExtEn <= 6'h38;
    tick(3);
    chk(port3PinOeN, 6'h38);
    chk(port3PinOut[2:0], 3'h2);
    rdChk(A_P3DAT, 8'hd2);
    timerCompareEn <= 6'h21;
    timerCompareLevel <= 6'h01;
    tick(4);
    chk({port3PinOeN[5], port3PinOeN[0], port3PinOut[5], port3PinOut[0]}, 4'h1);
    rdChk(A_P3DAT, 8'hd3);
    swStandby <= 1'b1;
    tick(2);
    timerCompareLevel <= 6'h20;
    tick(3);
    chk(port3PinOeN, 6'h38);
    chk(port3PinOut[2:0], 3'h2);
    chk(port2PinOeN, 8'hf0);
    swStandby <= 1'b0;
    timerCompareEn <= 6'h00;
    wr(32'h0000_0010, 8'hff);
    rdChk(A_P3DAT, 8'hd2);
    dataBusLowByteOut <= 8'h3c;
    dataBusLowByteDrive <= 1'b1;
    foreach (busModes[i]) begin
      opMode <= busModes[i];
      wr(A_P2DAT, 8'h00);
      chk(lastResp, 2'h0);
      tick(2);
      chk(port2PinOut, 8'h3c);
      chk(busByteIn, 8'h3c);
      chk(port2PinOeN, 8'h00);
      rdChk(A_P2DAT, 8'hff);
      swStandby <= 1'b1;
      tick(3);
      chk(port2PinOeN, 8'hff);
      swStandby <= 1'b0;
    end
    opMode <= 3'h2;
    tick(3);
    chk(port2PinOeN, 8'hf0);
    rdChk(A_P2DAT, 8'h95);
    port3ExtEn <= 6'h3f;
    hwStandby <= 1'b1;
    tick(3);
    chk(port3PinOeN, 6'h3f);
    hwStandby <= 1'b0;
    rdChk(A_P3DAT, 8'hd5);
    chk(port2PinOeN, 8'hff);
    conclude();
  end
endmodule : test_io_ports_two_and_three
`default_nettype wire

// file: hdl/iop_axil_slave.sv
// AXI4-Lite slave front end: takes one write and one read at a time.
`default_nettype none
`include "iop_cfg.svh"
module iop_axil_slave
  import iop_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Write address and data
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic [31:0] wrAddr,
  output logic [7:0] wrData,
  output logic wrStrobe,
  input wire logic wrHit,
  output logic [31:0] rdAddr,
  input wire logic [7:0] rdData,
  input wire logic rdHit
);
  logic awHeld_r;
  logic wHeld_r;
  logic wLane0_r;
  logic arHeld_r;
  logic awTake;
  logic wTake;
  logic arTake;
  logic wrDone;
  logic bFree;

  assign awTake = awvalid & awready;
  assign wTake = wvalid & wready;
  assign arTake = arvalid & arready;
  // The write happens once both halves are held and no response is pending.
  assign wrDone = awHeld_r & wHeld_r & ~bvalid;
  assign wrStrobe = wrDone & wLane0_r;
  assign bFree = bvalid & bready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      wLane0_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      wrAddr <= '0;
      wrData <= '0;
      bvalid <= 1'b0;
      bresp <= `IOP_RESP_OKAY;
    end else begin
      if (awTake) begin
        wrAddr <= awaddr;
        awHeld_r <= 1'b1;
        awready <= 1'b0;
      end
      if (wTake) begin
        wrData <= wdata[7:0];
        wLane0_r <= wstrb[0];
        wHeld_r <= 1'b1;
        wready <= 1'b0;
      end
      if (wrDone) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrHit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
      end
      if (bFree) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Reads take one cycle to decode, so rvalid follows the address by two edges.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arHeld_r <= 1'b0;
      arready <= 1'b1;
      rdAddr <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `IOP_RESP_OKAY;
    end else begin
      if (arTake) begin
        rdAddr <= araddr;
        arHeld_r <= 1'b1;
        arready <= 1'b0;
      end
      if (arHeld_r) begin
        arHeld_r <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, rdHit ? rdData : 8'h00};
        rresp <= rdHit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
      end
      if (rvalid & rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : iop_axil_slave
`default_nettype wire

// file: hdl/iop_cfg.svh
// Register indices, reset values and bus codes of the second and third I/O ports.
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

// Register indices; the byte address on the register bus is four times the index.
`define IOP_IDX_PORT2_DIR 16'hfe81
`define IOP_IDX_PORT2_DATA 16'hfe83
`define IOP_IDX_PORT3_DIR 16'hfe84
`define IOP_IDX_PORT3_DATA 16'hfe86
`define IOP_ADDR_LSB 2
`define IOP_IDX_W 16

// Reset values.
`define IOP_PORT2_DIR_RST 8'h00
`define IOP_PORT2_DATA_RST 8'h00
`define IOP_PORT3_DIR_RST 8'hc0
`define IOP_PORT3_DATA_RST 8'hc0

// Read values of write-only or unused bits.
`define IOP_ALL_ONES 8'hff
`define IOP_P3_UNUSED 2'h3

// Field layout of the third port.
`define IOP_P3_MSB 5

// Operating mode codes.
`define IOP_MODE_EXP_MIN_A 3'h1
`define IOP_MODE_EXP_MIN_B 3'h2
`define IOP_MODE_SINGLE 3'h7

// Register bus response codes.
`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2

`endif

// file: hdl/iop_pkg.sv
// Types shared by the I/O port block.
`default_nettype none
package iop_pkg;
  typedef logic [7:0] iop_byte_t;
  typedef logic [1:0] iop_resp_t;
  typedef enum logic [1:0] {
    IOP_P2_BUS = 2'h0,
    IOP_P2_GPIO = 2'h1,
    IOP_P2_FLOAT = 2'h2
  } iop_p2fn_t;
endpackage : iop_pkg
`default_nettype wire

// file: hdl/iop_ports.sv
// Second and third general-purpose I/O ports with AXI4-Lite register access.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none
`include "iop_cfg.svh"
module iop_ports
  import iop_pkg::*;
#(
  parameter int P3W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Chip state
  input wire logic [2:0] opMode,
  input wire logic hwStandby,
  input wire logic swStandby,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // External bus controller, low data byte
  input wire logic [7:0] dataBusLowByteOut,
  input wire logic dataBusLowByteDrive,
  output logic [7:0] dataBusLowByteIn,
  // Timer compare outputs
  input wire logic [P3W-1:0] timerCompareEn,
  input wire logic [P3W-1:0] timerCompareLevel,
  // Second port pins
  input wire logic [7:0] port2PinIn,
  output logic [7:0] port2PinOut,
  output logic [7:0] port2PinOeN,
  // Third port pins
  input wire logic [P3W-1:0] port3PinIn,
  output logic [P3W-1:0] port3PinOut,
  output logic [P3W-1:0] port3PinOeN
);
  iop_byte_t port2DirReg_r;
  iop_byte_t port2DataReg_r;
  iop_byte_t port3DirReg_r;
  iop_byte_t port3DataReg_r;
  logic [7:0] p2Sync;
  logic [P3W-1:0] p3Sync;
  logic [31:0] wrAddr;
  logic [31:0] rdAddr;
  logic [7:0] wrData;
  logic wrStrobe;
  logic wrHit;
  logic rdHit;
  logic [7:0] rdData;

  iop_sync #(.W(8)) u_sync2 (
    .clk(clk),
    .nrst(nrst),
    .din(port2PinIn),
    .dout(p2Sync)
  );

  iop_sync #(.W(P3W)) u_sync3 (
    .clk(clk),
    .nrst(nrst),
    .din(port3PinIn),
    .dout(p3Sync)
  );

  iop_axil_slave u_bus (
    .clk(clk),
    .nrst(nrst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrobe(wrStrobe),
    .wrHit(wrHit),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdHit(rdHit)
  );

  // Mode decode; the mode pins are static straps held by the system.
  wire singleChip = (opMode == `IOP_MODE_SINGLE);
  wire port2Gpio = singleChip | (opMode == `IOP_MODE_EXP_MIN_B);
  wire port2Float = swStandby & ~singleChip;
  wire iop_p2fn_t port2Fn = port2Gpio ? (port2Float ? IOP_P2_FLOAT : IOP_P2_GPIO)
                                      : (port2Float ? IOP_P2_FLOAT : IOP_P2_BUS);

  // Timer claims are dropped in software standby because the timer is reset there.
  wire [P3W-1:0] timerOwn = timerCompareEn & {P3W{~swStandby}};

  // Register decode on word indices.
  wire [`IOP_IDX_W-1:0] wrIdx = wrAddr[`IOP_ADDR_LSB +: `IOP_IDX_W];
  wire [`IOP_IDX_W-1:0] rdIdx = rdAddr[`IOP_ADDR_LSB +: `IOP_IDX_W];
  wire wrUpper0 = (wrAddr[31:`IOP_ADDR_LSB+`IOP_IDX_W] == '0) & (wrAddr[1:0] == 2'h0);
  wire rdUpper0 = (rdAddr[31:`IOP_ADDR_LSB+`IOP_IDX_W] == '0) & (rdAddr[1:0] == 2'h0);
  wire wrP2Dir = wrUpper0 & (wrIdx == `IOP_IDX_PORT2_DIR);
  wire wrP2Data = wrUpper0 & (wrIdx == `IOP_IDX_PORT2_DATA);
  wire wrP3Dir = wrUpper0 & (wrIdx == `IOP_IDX_PORT3_DIR);
  wire wrP3Data = wrUpper0 & (wrIdx == `IOP_IDX_PORT3_DATA);
  wire rdP2Dir = rdUpper0 & (rdIdx == `IOP_IDX_PORT2_DIR);
  wire rdP2Data = rdUpper0 & (rdIdx == `IOP_IDX_PORT2_DATA);
  wire rdP3Dir = rdUpper0 & (rdIdx == `IOP_IDX_PORT3_DIR);
  wire rdP3Data = rdUpper0 & (rdIdx == `IOP_IDX_PORT3_DATA);
  assign wrHit = wrP2Dir | wrP2Data | wrP3Dir | wrP3Data;
  assign rdHit = rdP2Dir | rdP2Data | rdP3Dir | rdP3Data;

  // Per-pin second-port read value in the gpio modes.
  // A pin read is two edges old because it passes the synchroniser first.
  logic [7:0] p2GpioRead;
  for (genvar j = 0; j < 8; j++) begin : g_p2pin
    wire pinOutput = port2DirReg_r[j];
    assign p2GpioRead[j] = pinOutput ? port2DataReg_r[j] : p2Sync[j];
  end

  // Outside the gpio modes the data register is hidden behind the bus and reads ones.
  wire [7:0] p2DataRead = port2Gpio ? p2GpioRead : `IOP_ALL_ONES;

  // Per-pin third-port selection.
  // A timer claim outranks the direction bit, so software cannot fight the timer
  // for a pin; the claim is already masked off during software standby.
  logic [P3W-1:0] p3PinRead;
  logic [P3W-1:0] p3OutNxt;
  logic [P3W-1:0] p3OeNNxt;
  for (genvar i = 0; i < P3W; i++) begin : g_p3pin
    wire pinTimer = timerOwn[i];
    wire pinOutput = port3DirReg_r[i];
    wire storedBit = port3DataReg_r[i];
    // A driven pin reads back its stored bit; inputs and timer pins read the pin.
    assign p3PinRead[i] = (pinOutput & ~pinTimer) ? storedBit : p3Sync[i];
    assign p3OutNxt[i] = pinTimer ? timerCompareLevel[i] : storedBit;
    assign p3OeNNxt[i] = ~(pinOutput | pinTimer);
  end

  // The two unused upper bits always read as ones.
  wire [7:0] p3DataRead = {`IOP_P3_UNUSED, p3PinRead};

  assign rdData = rdP2Dir ? `IOP_ALL_ONES
                : rdP2Data ? p2DataRead
                : rdP3Dir ? `IOP_ALL_ONES
                : p3DataRead;

  // Second-port data writes are dropped while the port is the data bus.
  wire p2DataWe = wrStrobe & wrP2Data & port2Gpio;

  // Hardware standby reinitialises the registers; software standby keeps them.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port2DirReg_r <= `IOP_PORT2_DIR_RST;
      port2DataReg_r <= `IOP_PORT2_DATA_RST;
    end else if (hwStandby) begin
      port2DirReg_r <= `IOP_PORT2_DIR_RST;
      port2DataReg_r <= `IOP_PORT2_DATA_RST;
    end else begin
      if (wrStrobe & wrP2Dir) begin
        port2DirReg_r <= wrData;
      end
      if (p2DataWe) begin
        port2DataReg_r <= wrData;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port3DirReg_r <= `IOP_PORT3_DIR_RST;
      port3DataReg_r <= `IOP_PORT3_DATA_RST;
    end else if (hwStandby) begin
      port3DirReg_r <= `IOP_PORT3_DIR_RST;
      port3DataReg_r <= `IOP_PORT3_DATA_RST;
    end else begin
      if (wrStrobe & wrP3Dir) begin
        port3DirReg_r <= {`IOP_P3_UNUSED, wrData[`IOP_P3_MSB:0]};
      end
      if (wrStrobe & wrP3Data) begin
        port3DataReg_r <= {`IOP_P3_UNUSED, wrData[`IOP_P3_MSB:0]};
      end
    end
  end

  // Pin drive selection.
  logic [7:0] p2OutNxt;
  logic [7:0] p2OeNNxt;
  always_comb begin
    case (port2Fn)
      IOP_P2_BUS: begin
        p2OutNxt = dataBusLowByteOut;
        p2OeNNxt = {8{~dataBusLowByteDrive}};
      end
      IOP_P2_GPIO: begin
        p2OutNxt = port2DataReg_r;
        p2OeNNxt = ~port2DirReg_r;
      end
      default: begin
        p2OutNxt = port2DataReg_r;
        p2OeNNxt = `IOP_ALL_ONES;
      end
    endcase
  end

  // Pins float during hardware standby; outputs come straight from flops.
  // Registering the pins costs one edge of latency but keeps glitches off the board.
  wire [7:0] p2OeNFinal = hwStandby ? `IOP_ALL_ONES : p2OeNNxt;
  wire [P3W-1:0] p3OeNFinal = hwStandby ? {P3W{1'b1}} : p3OeNNxt;

  // Second port pins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port2PinOut <= '0;
      port2PinOeN <= '1;
    end else begin
      port2PinOut <= p2OutNxt;
      port2PinOeN <= p2OeNFinal;
    end
  end

  // Third port pins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port3PinOut <= '0;
      port3PinOeN <= '1;
    end else begin
      port3PinOut <= p3OutNxt;
      port3PinOeN <= p3OeNFinal;
    end
  end

  // Bus byte back to the external bus controller.
  // It is the synchronised pin level, so it lags the pins by three edges in all.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataBusLowByteIn <= '0;
    end else begin
      dataBusLowByteIn <= p2Sync;
    end
  end
endmodule : iop_ports
`default_nettype wire

// file: hdl/iop_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`default_nettype none
module iop_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1_r <= '0;
      dout <= '0;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule : iop_sync
`default_nettype wire
